// ### hdl/cct_pkg.sv
// Constants for the charger threshold register bank: register indices,
// reset values, writable masks, field positions and decoded units.
// Assumes a 32-bit AXI4-Lite slave with each register in one aligned word.
package cct_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_TERM   = 6'h03;
    localparam logic [5:0] IDX_CHG    = 6'h04;
    localparam logic [5:0] IDX_VTHR   = 6'h05;
    localparam int         ADDR_W     = 8;

    // Values after reset.
    localparam logic [7:0] RST_TERM   = 8'h01;
    localparam logic [7:0] RST_CHG    = 8'h3e;
    localparam logic [7:0] RST_VTHR   = 8'h6b;

    // Bits that software may change; all others hold their fixed value.
    localparam logic [7:0] WMASK_TERM = 8'h03;
    localparam logic [7:0] WMASK_CHG  = 8'hdf;
    localparam logic [7:0] WMASK_VTHR = 8'h7f;

    // Field positions.
    localparam int CHG_C20_BIT   = 7;
    localparam int CHG_C10_BIT   = 6;
    localparam int CHG_ONE_BIT   = 5;
    localparam int CHG_FAST_LSB  = 2;
    localparam int CHG_TRK_LSB   = 0;
    localparam int VTHR_RCH_LSB  = 5;
    localparam int VTHR_DEAD_LSB = 3;
    localparam int VTHR_WEAK_LSB = 0;
    localparam int TERM_SEL_LSB  = 0;

    // Decoded units: termination in 0.1 mA, fast charge in mA,
    // trickle in mA, recharge in mV, battery thresholds in 10 mV.
    localparam logic [10:0] TERM_BASE  = 11'd325;
    localparam logic [10:0] TERM_STEP  = 11'd200;
    localparam logic [10:0] TERM_FLOOR = 11'd275;
    localparam logic [10:0] FAST_BASE  = 11'd550;
    localparam logic [10:0] FAST_STEP  = 11'd100;
    localparam logic [8:0]  RCH_BASE   = 9'd80;
    localparam logic [8:0]  RCH_STEP   = 9'd60;
    localparam logic [8:0]  WEAK_BASE  = 9'd270;
    localparam logic [8:0]  WEAK_STEP  = 9'd10;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // End-of-charge mode chosen by the priority of the control bits.
    typedef enum logic [1:0] {
        TERM_ABS,
        TERM_C10,
        TERM_C20
    } cct_term_mode_t;

    // Clamps a fractional termination level to its floor.
    function automatic logic [10:0] term_floor(input logic [10:0] lvl);
        term_floor = (lvl < TERM_FLOOR) ? TERM_FLOOR : lvl;
    endfunction

endpackage

// ### hdl/cct_decode.sv
// Registered decoder turning the raw register fields into charger settings.
// Assumes its inputs are the register bank's flip-flops, same clock.
`timescale 1ns/10ps
module cct_decode
    import cct_pkg::*;
(
    // Clock and reset.
    input  wire logic           clock,
    input  wire logic           reset,
    // Raw register contents.
    input  wire logic [7:0]     chg_reg,
    input  wire logic [7:0]     vthr_reg,
    input  wire logic [7:0]     term_reg,
    // Decoded settings.
    output cct_term_mode_t      term_mode_q,
    output logic [10:0]         term_level_q,
    output logic [10:0]         fast_ma_q,
    output logic [4:0]          trickle_ma_q,
    output logic [8:0]          recharge_mv_q,
    output logic [8:0]          dead_cv_q,
    output logic [8:0]          weak_cv_q
);

    cct_term_mode_t term_mode_d;
    logic [10:0]    term_level_d;
    logic [10:0]    fast_ma_d;
    logic [4:0]     trickle_ma_d;
    logic [8:0]     recharge_mv_d;
    logic [8:0]     dead_cv_d;
    logic [8:0]     weak_cv_d;
    logic [1:0]     term_current_sel;
    logic [2:0]     fast_current_sel;
    logic [1:0]     trickle_current_sel;
    logic [1:0]     recharge_hyst_sel;
    logic [1:0]     dead_batt_thresh_sel;
    logic [2:0]     weak_batt_thresh_sel;

    // Field extraction and the look-up of each setting.
    always_comb begin
        term_current_sel     = term_reg[TERM_SEL_LSB +: 2];
        fast_current_sel     = chg_reg[CHG_FAST_LSB +: 3];
        trickle_current_sel  = chg_reg[CHG_TRK_LSB +: 2];
        recharge_hyst_sel    = vthr_reg[VTHR_RCH_LSB +: 2];
        dead_batt_thresh_sel = vthr_reg[VTHR_DEAD_LSB +: 2];
        weak_batt_thresh_sel = vthr_reg[VTHR_WEAK_LSB +: 3];
        fast_ma_d     = FAST_BASE
                      + FAST_STEP * {8'h00, fast_current_sel};
        recharge_mv_d = RCH_BASE
                      + RCH_STEP * {7'h00, recharge_hyst_sel};
        weak_cv_d     = WEAK_BASE
                      + WEAK_STEP * {6'h00, weak_batt_thresh_sel};
        // Codes 10 and 11 both give the full trickle current.
        unique case (trickle_current_sel)
            2'h0:    trickle_ma_d = 5'd5;
            2'h1:    trickle_ma_d = 5'd10;
            default: trickle_ma_d = 5'd20;
        endcase
        // The top code jumps well above the evenly spaced lower ones.
        unique case (dead_batt_thresh_sel)
            2'h0:    dead_cv_d = 9'd240;
            2'h1:    dead_cv_d = 9'd250;
            2'h2:    dead_cv_d = 9'd260;
            default: dead_cv_d = 9'd330;
        endcase
        // One-twentieth beats one-tenth, which beats the absolute field.
        // Fast current in mA equals C/10 in 0.1 mA, half of it is C/20.
        if (chg_reg[CHG_C20_BIT]) begin
            term_mode_d  = TERM_C20;
            term_level_d = term_floor({1'b0, fast_ma_d[10:1]});
        end else if (chg_reg[CHG_C10_BIT]) begin
            term_mode_d  = TERM_C10;
            term_level_d = term_floor(fast_ma_d);
        end else begin
            term_mode_d  = TERM_ABS;
            term_level_d = TERM_BASE
                         + TERM_STEP * {9'h000, term_current_sel};
        end
    end

    // Outputs settle one edge after the register changes.
    always_ff @(posedge clock) begin
        if (reset) begin
            term_mode_q   <= TERM_ABS;
            term_level_q  <= TERM_BASE + TERM_STEP;
            fast_ma_q     <= 11'd1250;
            trickle_ma_q  <= 5'd20;
            recharge_mv_q <= 9'd260;
            dead_cv_q     <= 9'd250;
            weak_cv_q     <= 9'd300;
        end else begin
            term_mode_q   <= term_mode_d;
            term_level_q  <= term_level_d;
            fast_ma_q     <= fast_ma_d;
            trickle_ma_q  <= trickle_ma_d;
            recharge_mv_q <= recharge_mv_d;
            dead_cv_q     <= dead_cv_d;
            weak_cv_q     <= weak_cv_d;
        end
    end

endmodule

// ### hdl/cct_regs.sv
// Charger threshold register bank behind an AXI4-Lite slave port.
// Assumes a master that keeps the AXI4-Lite handshake rules and one clock.
// Overview of operation
// - Termination field picks 32.5 to 92.5 mA, default 01.
// - C/20 bit wins, floor 27.5 mA.
// - C/10 bit beats absolute field, floor 27.5 mA.
// - Fast current 550 to 1250 mA, default 111.
// - Trickle current 5/10/20/20 mA, default 10.
// - Recharge hysteresis 80 to 260 mV, default 11.
// - Dead battery 2.4/2.5/2.6/3.3 V, default 01.
// - Weak battery 2.7 to 3.4 V, default 011.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module cct_regs
    import cct_pkg::*;
(
    // Clock and reset.
    input  wire logic               clock,
    input  wire logic               reset,
    // AXI4-Lite write address and data.
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Decoded settings for the charger loop.
    output cct_term_mode_t          term_mode,
    output logic [10:0]             term_level_dma,
    output logic [10:0]             fast_current_ma,
    output logic [4:0]              trickle_current_ma,
    output logic [8:0]              recharge_hyst_mv,
    output logic [8:0]              dead_batt_cv,
    output logic [8:0]              weak_batt_cv
);

    // Register bank and bus state.
    logic [7:0]        chg_q, chg_d;
    logic [7:0]        vthr_q, vthr_d;
    logic [7:0]        term_q, term_d;
    logic              aw_held_q, aw_held_d;
    logic              w_held_q, w_held_d;
    logic [5:0]        waddr_q, waddr_d;
    logic [7:0]        wdata_q, wdata_d;
    logic              wlane_q, wlane_d;
    logic              awready_q, awready_d;
    logic              wready_q, wready_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              arready_q, arready_d;
    logic              rvalid_q, rvalid_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [1:0]        rresp_q, rresp_d;
    logic              commit;
    logic [5:0]        ridx;

    // True for the three word indices that hold a register.
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx == IDX_CHG) || (idx == IDX_VTHR) ||
                    (idx == IDX_TERM);
    endfunction

    // Merges a write into a register so fixed bits keep their value.
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wr,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wr & mask);
    endfunction

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Write path: address and data are caught in either order, then the
    // write lands one edge after both are held and the response is raised.
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wlane_d   = wlane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        chg_d     = chg_q;
        vthr_d    = vthr_q;
        term_d    = term_q;
        commit    = aw_held_q && w_held_q && !bvalid_q;
        if (s_axi_awvalid && awready_q) begin
            aw_held_d = 1'b1;
            waddr_d   = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && wready_q) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata[7:0];
            wlane_d  = s_axi_wstrb[0];
        end
        if (commit) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
            // Only byte lane 0 carries register bits; upper lanes are void.
            if (wlane_q) begin
                unique case (waddr_q)
                    IDX_CHG:  chg_d  = merge(chg_q, wdata_q, WMASK_CHG);
                    IDX_VTHR: vthr_d = merge(vthr_q, wdata_q, WMASK_VTHR);
                    IDX_TERM: term_d = merge(term_q, wdata_q, WMASK_TERM);
                    default:  ;
                endcase
            end
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Holding one write at a time keeps the two channels paired.
        awready_d = !aw_held_d && !bvalid_d;
        wready_d  = !w_held_d && !bvalid_d;
    end

    // Read path: one cycle from the address handshake to valid data.
    always_comb begin
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        ridx      = s_axi_araddr[7:2];
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
            unique case (ridx)
                IDX_CHG:  rdata_d = {24'h000000, chg_q};
                IDX_VTHR: rdata_d = {24'h000000, vthr_q};
                IDX_TERM: rdata_d = {24'h000000, term_q};
                default:  rdata_d = 32'h00000000;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    // Registers everything; ready lines stay low during reset.
    always_ff @(posedge clock) begin
        if (reset) begin
            chg_q     <= RST_CHG;
            vthr_q    <= RST_VTHR;
            term_q    <= RST_TERM;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            waddr_q   <= 6'h00;
            wdata_q   <= 8'h00;
            wlane_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= RESP_OKAY;
        end else begin
            chg_q     <= chg_d;
            vthr_q    <= vthr_d;
            term_q    <= term_d;
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wlane_q   <= wlane_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // Settings decoder; its outputs are flip-flops.
    cct_decode cct_decode_i (
        .clock         (clock),
        .reset         (reset),
        .chg_reg       (chg_q),
        .vthr_reg      (vthr_q),
        .term_reg      (term_q),
        .term_mode_q   (term_mode),
        .term_level_q  (term_level_dma),
        .fast_ma_q     (fast_current_ma),
        .trickle_ma_q  (trickle_current_ma),
        .recharge_mv_q (recharge_hyst_mv),
        .dead_cv_q     (dead_batt_cv),
        .weak_cv_q     (weak_batt_cv)
    );

    // Checks tying decoded settings, reset values and fixed bits to the registers, and read handshake checks.
    a_term_abs_code: assert property (
        @(posedge clock) disable iff (reset)
        (!chg_q[7] && !chg_q[6] && term_q[1:0] == 2'h0)
        |=> (term_level_dma == 11'd325 && term_mode == TERM_ABS))
        else $error("Absolute termination level wrong.");
    a_term_reset_val: assert property (
        @(posedge clock)
        reset ##1 !reset
        |-> term_q == 8'h01 && chg_q == 8'h3e && vthr_q == 8'h6b)
        else $error("Register reset value wrong.");
    a_c20_wins_floor: assert property (
        @(posedge clock) disable iff (reset)
        (chg_q[7] && chg_q[6] && chg_q[4:2] == 3'h0)
        |=> (term_level_dma == 11'd275 && term_mode == TERM_C20))
        else $error("C/20 priority or floor wrong.");
    a_c10_level: assert property (
        @(posedge clock) disable iff (reset)
        (!chg_q[7] && chg_q[6] && chg_q[4:2] == 3'h7)
        |=> (term_level_dma == 11'd1250 && term_mode == TERM_C10))
        else $error("C/10 level wrong.");
    a_fast_step: assert property (
        @(posedge clock) disable iff (reset)
        chg_q[4:2] == 3'h3 |=> fast_current_ma == 11'd850)
        else $error("Fast current wrong.");
    a_trickle_top: assert property (
        @(posedge clock) disable iff (reset)
        chg_q[1:0] == 2'h3 |=> trickle_current_ma == 5'd20)
        else $error("Trickle current wrong.");
    a_recharge_low: assert property (
        @(posedge clock) disable iff (reset)
        vthr_q[6:5] == 2'h0 |=> recharge_hyst_mv == 9'd80)
        else $error("Recharge hysteresis wrong.");
    a_dead_top: assert property (
        @(posedge clock) disable iff (reset)
        vthr_q[4:3] == 2'h3 |=> dead_batt_cv == 9'd330)
        else $error("Dead battery threshold wrong.");
    a_weak_top: assert property (
        @(posedge clock) disable iff (reset)
        vthr_q[2:0] == 3'h7 |=> weak_batt_cv == 9'd340)
        else $error("Weak battery threshold wrong.");
    a_fixed_bits: assert property (
        @(posedge clock) disable iff (reset)
        commit |=> chg_q[5] && !vthr_q[7] && term_q[7:2] == 6'h00)
        else $error("Fixed bit changed by a write.");
    a_read_answer: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read answer missing.");
    a_read_hold: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_rvalid && !s_axi_rready)
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read answer dropped.");

endmodule

// ### bench/cct_host.sv
// Host model: an AXI4-Lite master that software uses to reach the bank.
// Assumes one clock and a slave that answers on its own time.
`timescale 1ns/10ps
module cct_host
    import cct_pkg::*;
(
    // Clock.
    input  wire logic              clock,
    // Write address and data.
    output logic [ADDR_W-1:0]      s_axi_awaddr,
    output logic                   s_axi_awvalid,
    input  wire logic              s_axi_awready,
    output logic [31:0]            s_axi_wdata,
    output logic [3:0]             s_axi_wstrb,
    output logic                   s_axi_wvalid,
    input  wire logic              s_axi_wready,
    // Write response.
    input  wire logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_bvalid,
    output logic                   s_axi_bready,
    // Read channels.
    output logic [ADDR_W-1:0]      s_axi_araddr,
    output logic                   s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic [31:0]       s_axi_rdata,
    input  wire logic [1:0]        s_axi_rresp,
    input  wire logic              s_axi_rvalid,
    output logic                   s_axi_rready
);

    // Idle bus at time zero; the payload is not meaningful while idle.
    initial begin
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
    end

    // One write; each channel is released at its own handshake edge and
    // its payload is scrambled so that a late sample shows up as wrong.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~{24'h0, d};
            end
        end
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // One read; rready rises only once the answer stands, so the slave
    // must hold it a cycle, then stays high until the data is taken.
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        s_axi_rready  <= 1'b1;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

endmodule

// ### bench/test_charger_current_threshold_regs.sv
// Self-checking bench for the charger threshold register bank.
// Assumes the host model above drives every bus input of the bank.
`timescale 1ns/10ps
module test_charger_current_threshold_regs
    import cct_pkg::*;
;
    logic               clock = 1'b0;
    logic               reset = 1'b1;
    logic [ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic [3:0]         s_axi_wstrb;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic               s_axi_rready;
    cct_term_mode_t     term_mode;
    logic [10:0]        term_level_dma, fast_current_ma;
    logic [4:0]         trickle_current_ma;
    logic [8:0]         recharge_hyst_mv, dead_batt_cv, weak_batt_cv;
    int                 num_errors = 0;
    int                 n_checks = 0;
    int                 cycles = 0;
    logic [4:0]         trk_tbl [4] = '{5'h05, 5'h0a, 5'h14, 5'h14};
    logic [8:0]         dead_tbl [4] = '{9'h0f0, 9'h0fa, 9'h104, 9'h14a};
    localparam logic [7:0] A_TERM = {IDX_TERM, 2'b00};
    localparam logic [7:0] A_CHG  = {IDX_CHG, 2'b00};
    localparam logic [7:0] A_VTHR = {IDX_VTHR, 2'b00};

    // Clock at 200 MHz.
    always #2.5 clock = ~clock;

    cct_regs cct_regs_i (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .term_mode,
        .term_level_dma, .fast_current_ma, .trickle_current_ma,
        .recharge_hyst_mv, .dead_batt_cv, .weak_batt_cv);

    cct_host cct_host_i (.clock, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs well under a thousand cycles.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        cct_host_i.write_reg(a, d, s, r);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        cct_host_i.read_reg(a, d, r);
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // Decoded outputs trail a register write by one edge; let it land.
    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // Main sequence.
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        rd(A_TERM, {24'h0, RST_TERM}, RESP_OKAY);
        rd(A_CHG, {24'h0, RST_CHG}, RESP_OKAY);
        rd(A_VTHR, {24'h0, RST_VTHR}, RESP_OKAY);
        settle();
        chk(term_mode, TERM_ABS);
        chk(term_level_dma, 32'h20d);
        chk(fast_current_ma, 32'h4e2);
        chk(trickle_current_ma, 32'h14);
        chk(recharge_hyst_mv, 32'h104);
        chk(dead_batt_cv, 32'hfa);
        chk(weak_batt_cv, 32'h12c);
        // Every absolute termination code, back to back.
        for (int i = 0; i < 4; i++) begin
            wr(A_TERM, 8'(i), 4'h1, RESP_OKAY);
            settle();
            chk(term_level_dma, TERM_BASE + TERM_STEP * i);
        end
        // Every fast code under C/10, then C/20 on top of C/10.
        for (int i = 0; i < 8; i++) begin
            wr(A_CHG, {3'b011, 3'(i), 2'b10}, 4'h1, RESP_OKAY);
            settle();
            chk(fast_current_ma, FAST_BASE + FAST_STEP * i);
            chk(term_mode, TERM_C10);
            chk(term_level_dma, FAST_BASE + FAST_STEP * i);
            wr(A_CHG, {3'b111, 3'(i), 2'b10}, 4'h1, RESP_OKAY);
            settle();
            chk(term_mode, TERM_C20);
            chk(term_level_dma, TERM_FLOOR + 32'h32 * i);
        end
        // Trickle codes with both fractional bits low.
        for (int i = 0; i < 4; i++) begin
            wr(A_CHG, {6'h08, 2'(i)}, 4'h1, RESP_OKAY);
            settle();
            chk(trickle_current_ma, trk_tbl[i]);
            chk(term_mode, TERM_ABS);
            chk(term_level_dma, 32'h39d);
        end
        // Voltage fields, every code of each.
        for (int i = 0; i < 8; i++) begin
            wr(A_VTHR, {1'b1, 2'(i), 2'(i), 3'(i)}, 4'h1, RESP_OKAY);
            settle();
            chk(recharge_hyst_mv, RCH_BASE + RCH_STEP * (i % 4));
            chk(dead_batt_cv, dead_tbl[i % 4]);
            chk(weak_batt_cv, WEAK_BASE + WEAK_STEP * i);
            rd(A_VTHR, {25'h0, 2'(i), 2'(i), 3'(i)}, RESP_OKAY);
        end
        // Fixed bits, a write with no strobe and an unmapped address.
        wr(A_CHG, 8'h00, 4'h1, RESP_OKAY);
        rd(A_CHG, 32'h20, RESP_OKAY);
        wr(A_TERM, 8'hff, 4'h1, RESP_OKAY);
        rd(A_TERM, 32'h03, RESP_OKAY);
        wr(A_TERM, 8'h00, 4'h0, RESP_OKAY);
        rd(A_TERM, 32'h03, RESP_OKAY);
        wr(8'h3c, 8'hff, 4'h1, RESP_SLVERR);
        rd(8'h3c, 32'h0, RESP_SLVERR);
        // A reset in mid-run must bring every default back.
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        rd(A_VTHR, {24'h0, RST_VTHR}, RESP_OKAY);
        settle();
        chk(term_level_dma, 32'h20d);
        chk(weak_batt_cv, 32'h12c);
        complete_run();
    end

endmodule
